// *** rtl/eeprom_pkg.sv ***
package eeprom_pkg;

	// Register bus map: CSR byte address, EEPROM region tag and array geometry
	localparam logic [11:0] CSR_ADDR       = 12'h002C;
	localparam logic [1:0]  EE_REGION_TAG  = 2'h1;
	localparam int          EE_BYTES       = 256;
	localparam int          LATCH_N        = 16;
	localparam int          ROW_W          = 4;
	localparam int          COL_W          = 4;

	// Control/status field positions, reset values and erased cell value
	localparam int          IE_BIT         = 2;
	localparam int          LAT_BIT        = 1;
	localparam int          PGM_BIT        = 0;
	localparam logic [7:0]  CSR_RESET      = 8'h00;
	localparam logic [7:0]  LATCH_RESET    = 8'hFF;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;

	// Cell timing; printed nowhere, so plain defaults
	localparam int          CLK_MHZ        = 25;
	localparam int          ERASE_TIME_US  = 5000;
	localparam int          PROG_TIME_US   = 5000;
	localparam int          ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
	localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
	localparam int          TIMER_W        = 18;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ERASE = 2'b01,
		ST_PROG  = 2'b10,
		ST_HALT  = 2'b11
	} ee_state_t;

endpackage : eeprom_pkg

// *** rtl/cycle_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
	parameter int W = 18
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic         start,
	input  wire logic         abort,
	input  wire logic [W-1:0] load,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
		logic         done;
	} tmr_t;

	tmr_t s_r;
	tmr_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		if (abort) begin
			s_nxt.busy = 1'b0;
		end else if (start) begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt  = load;
		end else if (s_r.busy) begin
			if (s_r.cnt <= W'(1)) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt - W'(1);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign done = s_r.done;
endmodule : cycle_timer
`default_nettype wire

// *** rtl/eeprom_cell_array.sv ***
`timescale 1ns/100ps
`default_nettype none
module eeprom_cell_array
	import eeprom_pkg::*;
#(
	parameter int ROWS = 16,
	parameter int COLS = 16
) (
	input  wire logic                    mclk,
	input  wire logic [ROW_W+COL_W-1:0]  rd_addr,
	output logic      [7:0]              rd_data,
	input  wire logic                    erase_go,
	input  wire logic                    prog_go,
	input  wire logic [ROW_W-1:0]        row,
	input  wire logic [COLS-1:0]         mask,
	input  wire logic [COLS-1:0][7:0]    data
);
	// Nonvolatile cells: deliberately no reset
	logic [7:0] cells [ROWS*COLS];

	always_ff @(posedge mclk) begin
		for (int c = 0; c < COLS; c++) begin
			if (mask[c] && erase_go) begin
				cells[{row, COL_W'(c)}] <= ERASED_BYTE;
			end else if (mask[c] && prog_go) begin
				cells[{row, COL_W'(c)}] <= data[c];
			end
		end
	end

	assign rd_data = cells[rd_addr];
endmodule : eeprom_cell_array
`default_nettype wire

// *** rtl/data_eeprom_write_controller.sv ***
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module data_eeprom_write_controller
	import eeprom_pkg::*;
#(
	parameter int ERASE_CNT = ERASE_CYCLES,
	parameter int PROG_CNT  = PROG_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	input  wire logic        fetch_i,
	input  wire logic        vector_fetch,
	input  wire logic        wait_for_interrupt_instr,
	input  wire logic        halt_instr,
	output logic             eeprom_irq,
	output logic             eeprom_waiting,
	output logic             eeprom_halted
);
	import eeprom_pkg::*;

	typedef struct packed {
		ee_state_t                 st;
		logic                      cycle_done_irq_enable;
		logic                      latch_mode_bit;
		logic                      program_cycle_bit;
		logic [ROW_W-1:0]          row;
		logic [LATCH_N-1:0][7:0]   latch_data;
		logic [LATCH_N-1:0]        latch_full;
		logic                      irq;
		logic                      waiting;
		logic                      halted;
		logic                      ack;
		logic                      err;
		logic [31:0]               dat;
	} ctl_t;

	ctl_t s_r;
	ctl_t s_nxt;

	logic                   req;
	logic                   is_csr;
	logic                   is_ee;
	logic [ROW_W+COL_W-1:0] ee_idx;
	logic [COL_W-1:0]       col;
	logic [7:0]             cell_rd;
	logic [7:0]             csr_view;
	logic                   erase_done;
	logic                   prog_done;
	logic                   tmr_done;
	logic                   tmr_start;
	logic                   tmr_abort;
	logic [TIMER_W-1:0]     tmr_load;
	logic                   erase_go;
	logic                   prog_go;
	logic                   wr_lat;
	logic                   wr_pgm;
	logic                   cycle_end;

	// One request per bus cycle; the answer flop blocks a retake
	assign req    = wb_cyc_i && wb_stb_i && !s_r.ack && !s_r.err;
	assign ee_idx = wb_adr_i[ROW_W+COL_W+1:2];
	assign col    = ee_idx[COL_W-1:0];

	always_comb begin
		is_csr = 1'b0;
		is_ee  = 1'b0;
		if (wb_adr_i == CSR_ADDR) begin
			is_csr = 1'b1;
		end else if (wb_adr_i[11:10] == EE_REGION_TAG) begin
			is_ee = 1'b1;
		end
	end

	assign csr_view = {5'h00, s_r.cycle_done_irq_enable, s_r.latch_mode_bit,
	                   s_r.program_cycle_bit};

	assign erase_done = (s_r.st == ST_ERASE) && tmr_done;
	assign prog_done  = (s_r.st == ST_PROG) && tmr_done;
	assign erase_go   = erase_done;
	assign prog_go    = prog_done;

	always_comb begin
		s_nxt     = s_r;
		s_nxt.ack = 1'b0;
		s_nxt.err = 1'b0;
		// Data bus reads zero outside a read answer
		s_nxt.dat = 32'h0000_0000;
		tmr_start = 1'b0;
		tmr_abort = 1'b0;
		tmr_load  = TIMER_W'(ERASE_CNT);
		wr_lat    = s_r.latch_mode_bit;
		wr_pgm    = s_r.program_cycle_bit;
		cycle_end = 1'b0;

		if (req) begin
			if (is_csr) begin
				s_nxt.ack = 1'b1;
				if (wb_we_i && wb_sel_i[0]) begin
					s_nxt.cycle_done_irq_enable = wb_dat_i[IE_BIT];
					wr_lat = wb_dat_i[LAT_BIT] ||
					         (s_r.program_cycle_bit && s_r.latch_mode_bit);
					// Program start needs latch mode on
					wr_pgm = wb_dat_i[PGM_BIT] && wr_lat;
				end else if (!wb_we_i) begin
					s_nxt.dat = {24'h00_0000, csr_view};
				end
			end else if (is_ee) begin
				if (wb_we_i) begin
					s_nxt.ack = 1'b1;
					if (s_r.latch_mode_bit && !s_r.program_cycle_bit && wb_sel_i[0]) begin
						s_nxt.latch_full[col] = 1'b1;
						s_nxt.latch_data[col] = s_r.latch_data[col] & wb_dat_i[7:0];
						s_nxt.row = ee_idx[ROW_W+COL_W-1:COL_W];
					end
				end else if (fetch_i) begin
					s_nxt.err = 1'b1;
				end else begin
					s_nxt.ack = 1'b1;
					// latch mode: bus left at zero
					if (!s_r.latch_mode_bit) begin
						s_nxt.dat = {24'h00_0000, cell_rd};
					end
				end
			end else begin
				s_nxt.err = 1'b1;
			end
		end

		s_nxt.latch_mode_bit    = wr_lat;
		s_nxt.program_cycle_bit = wr_pgm;

		case (s_r.st)
			ST_IDLE: begin
				if (wr_pgm && !s_r.program_cycle_bit) begin
					s_nxt.st  = ST_ERASE;
					tmr_start = 1'b1;
					tmr_load  = TIMER_W'(ERASE_CNT);
				end
			end
			ST_ERASE: begin
				if (!wr_pgm) begin
					// Software abort; cells not guaranteed
					s_nxt.st  = ST_IDLE;
					tmr_abort = 1'b1;
				end else if (erase_done) begin
					s_nxt.st  = ST_PROG;
					tmr_start = 1'b1;
					tmr_load  = TIMER_W'(PROG_CNT);
				end
			end
			ST_PROG: begin
				if (!wr_pgm) begin
					s_nxt.st  = ST_IDLE;
					tmr_abort = 1'b1;
				end else if (prog_done) begin
					s_nxt.st  = ST_IDLE;
					cycle_end = 1'b1;
				end
			end
			ST_HALT: begin
				if (!halt_instr) begin
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase

		if (halt_instr && s_r.st != ST_HALT) begin
			s_nxt.st  = ST_HALT;
			tmr_abort = 1'b1;
			tmr_start = 1'b0;
			cycle_end = 1'b0;
			if (s_r.program_cycle_bit) begin
				s_nxt.program_cycle_bit = 1'b0;
				s_nxt.latch_mode_bit    = 1'b0;
			end
		end

		if (cycle_end) begin
			s_nxt.program_cycle_bit = 1'b0;
			s_nxt.latch_mode_bit    = 1'b0;
		end

		// clear on falling latch bit or cycle end
		if (s_r.latch_mode_bit && !s_nxt.latch_mode_bit) begin
			s_nxt.latch_full = '0;
			s_nxt.latch_data = {LATCH_N{LATCH_RESET}};
		end

		// vector fetch clears; new event wins
		if (cycle_end && s_r.cycle_done_irq_enable) begin
			s_nxt.irq = 1'b1;
		end else if (vector_fetch) begin
			s_nxt.irq = 1'b0;
		end

		// wait only once no cycle runs
		s_nxt.waiting = wait_for_interrupt_instr && (s_nxt.st == ST_IDLE);
		s_nxt.halted  = (s_nxt.st == ST_HALT);
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_r                       <= '0;
			s_r.st                    <= ST_IDLE;
			s_r.cycle_done_irq_enable <= CSR_RESET[IE_BIT];
			s_r.latch_mode_bit        <= CSR_RESET[LAT_BIT];
			s_r.program_cycle_bit     <= CSR_RESET[PGM_BIT];
			s_r.latch_data            <= {LATCH_N{LATCH_RESET}};
		end else begin
			s_r <= s_nxt;
		end
	end

	cycle_timer #(
		.W (TIMER_W)
	) u_timer (
		.mclk  (mclk),
		.rst_b (rst_b),
		.start (tmr_start),
		.abort (tmr_abort),
		.load  (tmr_load),
		.done  (tmr_done)
	);

	eeprom_cell_array #(
		.ROWS (EE_BYTES / LATCH_N),
		.COLS (LATCH_N)
	) u_cells (
		.mclk     (mclk),
		.rd_addr  (ee_idx),
		.rd_data  (cell_rd),
		.erase_go (erase_go),
		.prog_go  (prog_go),
		.row      (s_r.row),
		.mask     (s_r.latch_full),
		.data     (s_r.latch_data)
	);

	assign wb_dat_o       = s_r.dat;
	assign wb_ack_o       = s_r.ack;
	assign wb_err_o       = s_r.err;
	assign eeprom_irq     = s_r.irq;
	assign eeprom_waiting = s_r.waiting;
	assign eeprom_halted  = s_r.halted;
endmodule : data_eeprom_write_controller
`default_nettype wire

// *** verification/eeprom_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module eeprom_monitor
	import eeprom_pkg::*;
#(
	parameter int ERASE_CNT = ERASE_CYCLES,
	parameter int PROG_CNT  = PROG_CYCLES
) (
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        fetch_i,
	input wire logic        vector_fetch,
	input wire logic        wait_for_interrupt_instr,
	input wire logic        halt_instr,
	input wire logic        eeprom_irq,
	input wire logic        eeprom_waiting,
	input wire logic        eeprom_halted
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic taken;
	assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	a_answer_next: assert property (taken |=> wb_ack_o ^ wb_err_o)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_fetch_refused: assert property (taken && !wb_we_i && fetch_i
		&& wb_adr_i[11:10] == EE_REGION_TAG |=> wb_err_o) else $error("fetch served");
	a_csr_reserved: assert property (wb_ack_o && !wb_we_i && wb_adr_i == CSR_ADDR
		|-> wb_dat_o[31:3] == 29'h0) else $error("reserved bits set");
	a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data driven outside answer");
	a_vector_clears: assert property (vector_fetch && eeprom_irq |=> !eeprom_irq)
		else $error("irq kept after vector fetch");
	a_halt_stops: assert property (halt_instr |=> eeprom_halted)
		else $error("halt not entered");
	a_halt_no_irq: assert property (eeprom_halted && !eeprom_irq |=> !eeprom_irq)
		else $error("irq raised in halt");
	a_wait_cause: assert property (eeprom_waiting |-> $past(wait_for_interrupt_instr))
		else $error("wait without request");
	c_irq: cover property ($rose(eeprom_irq));
	c_err: cover property (wb_err_o);
	c_wait: cover property ($rose(eeprom_waiting));
endmodule : eeprom_monitor
bind data_eeprom_write_controller eeprom_monitor #(.ERASE_CNT(ERASE_CNT), .PROG_CNT(PROG_CNT))
	u_mon (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .fetch_i(fetch_i), .vector_fetch(vector_fetch),
	.wait_for_interrupt_instr(wait_for_interrupt_instr), .halt_instr(halt_instr),
	.eeprom_irq(eeprom_irq), .eeprom_waiting(eeprom_waiting), .eeprom_halted(eeprom_halted));
`default_nettype wire

// *** verification/cpu_bus_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
	input  wire logic        mclk,
	input  wire logic        ack,
	input  wire logic        err,
	input  wire logic [31:0] rdat,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [11:0]      adr,
	output logic [3:0]       sel,
	output logic [31:0]      wdat,
	output logic             fetch
);
	initial begin
		{cyc, stb, we, fetch} = 4'h0;
		adr = 12'h000;
		sel = 4'h0;
		wdat = 32'h0000_0000;
	end
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic f, output logic [7:0] q, output logic e);
		@(posedge mclk);
		{cyc, stb, we, fetch} <= {2'b11, w, f};
		adr <= a;
		sel <= 4'h1;
		wdat <= {24'h00_0000, d};
		// Answer taken at the rising edge that samples it high
		do @(posedge mclk); while (!(ack || err));
		q = rdat[7:0];
		e = err;
		{cyc, stb, fetch} <= 3'b000;
		// Released lines wander so stale values are never trusted
		adr <= ~a;
		wdat <= ~wdat;
	endtask : bus
endmodule : cpu_bus_model
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
	import eeprom_pkg::*;
	logic        mclk, rst_b, vector_fetch, wait_in, halt_instr;
	logic        cyc, stb, we, ack, err, fetch, irq, waiting, halted, e;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat;
	logic [7:0]  q;
	int          err_count, n_tests;
	initial mclk = 1'b0;
	always #20 mclk = ~mclk;
	data_eeprom_write_controller #(.ERASE_CNT(20), .PROG_CNT(20)) dut (.mclk(mclk),
		.rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.fetch_i(fetch), .vector_fetch(vector_fetch), .wait_for_interrupt_instr(wait_in),
		.halt_instr(halt_instr), .eeprom_irq(irq), .eeprom_waiting(waiting),
		.eeprom_halted(halted));
	cpu_bus_model cpu (.mclk(mclk), .ack(ack), .err(err), .rdat(rdat), .cyc(cyc),
		.stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat), .fetch(fetch));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [11:0] ea(input int i);
		return 12'h400 + 12'(4 * i);
	endfunction : ea
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		cpu.bus(1'b1, a, d, 1'b0, q, e);
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [7:0] x);
		cpu.bus(1'b0, a, 8'h00, 1'b0, q, e);
		chk({24'h0, q}, {24'h0, x});
	endtask : rc
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 200) begin
			@(negedge mclk);
			n++;
		end
	endtask : wait_hi
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic wrap_up();
		$display("mismatches=%0d comparisons=%0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		#400000;
		err_count++;
		wrap_up();
	end
	initial begin
		{rst_b, vector_fetch, wait_in, halt_instr} = 4'h0;
		err_count = 0;
		n_tests = 0;
		tick(20);
		rst_b <= 1'b1;
		rc(CSR_ADDR, 8'h00);
		wr(CSR_ADDR, 8'hF8);
		rc(CSR_ADDR, 8'h00);
		cpu.bus(1'b0, 12'h100, 8'h00, 1'b0, q, e);
		chk(e, 1'b1);
		cpu.bus(1'b0, ea(5), 8'h00, 1'b1, q, e);
		chk(e, 1'b1);
		wr(CSR_ADDR, 8'h06);
		rc(ea(48), 8'h00);
		wr(ea(48), 8'hF0);
		wr(ea(48), 8'h3C);
		wr(ea(49), 8'hA5);
		wr(ea(50), 8'h5A);
		rc(ea(48), 8'h00);
		wr(CSR_ADDR, 8'h07);
		rc(CSR_ADDR, 8'h07);
		wr(CSR_ADDR, 8'h05);
		rc(CSR_ADDR, 8'h07);
		wait_hi(irq);
		chk(irq, 1'b1);
		rc(CSR_ADDR, 8'h04);
		@(posedge mclk) vector_fetch <= 1'b1;
		@(posedge mclk) vector_fetch <= 1'b0;
		@(negedge mclk) chk(irq, 1'b0);
		rc(ea(48), 8'h30);
		rc(ea(49), 8'hA5);
		wr(ea(50), 8'h00);
		rc(ea(50), 8'h5A);
		wr(CSR_ADDR, 8'h02);
		wr(ea(48), 8'h00);
		wr(CSR_ADDR, 8'h00);
		wr(CSR_ADDR, 8'h02);
		wr(ea(49), 8'h11);
		wr(CSR_ADDR, 8'h03);
		@(posedge mclk) wait_in <= 1'b1;
		tick(2);
		@(negedge mclk) chk(waiting, 1'b0);
		wait_hi(waiting);
		chk(waiting, 1'b1);
		chk(irq, 1'b0);
		@(posedge mclk) wait_in <= 1'b0;
		rc(CSR_ADDR, 8'h00);
		rc(ea(48), 8'h30);
		rc(ea(49), 8'h11);
		wr(CSR_ADDR, 8'h07);
		@(posedge mclk) halt_instr <= 1'b1;
		tick(2);
		@(negedge mclk) chk(halted, 1'b1);
		@(posedge mclk) halt_instr <= 1'b0;
		tick(60);
		chk(irq, 1'b0);
		rc(CSR_ADDR, 8'h04);
		@(posedge mclk) wait_in <= 1'b1;
		tick(1);
		@(negedge mclk) chk(waiting, 1'b1);
		wrap_up();
	end
endmodule : tb
`default_nettype wire
